/* File: core/adcop_port.sv */
/*
  Output port of a 16-bit sampling converter: parallel bus with byte
  order and coding selection, or a serial port sharing the same pins, in
  master or slave clocking. Configuration sits in an AXI4-Lite register.
  Assumes the conversion core runs on sys_clk and that pin level is
  resolved outside from the active-low output enables.
*/
`timescale 1ns/100ps
`include "adcop_regs.svh"

module adcop_port #(
  parameter int         ADDR_W    = 4,
  parameter logic [7:0] BASE_HALF = 8'h02  // Master half period, sys_clk cycles
) (
  input  wire logic                sys_clk,
  input  wire logic                srst,
  input  wire adcop_pkg::adcop_conv_t convIn,
  input  wire logic [15:0]         dataIn,
  output logic [15:0]              dataOut,
  output logic [15:0]              dataOeN,
  input  wire logic                csN,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  import adcop_pkg::*;

  logic [`ADCOP_CONFIG_WIDTH-1:0] configReg;
  adcop_cfg_t                     cfg;
  adcop_state_t                   stateReg;
  logic [15:0]                    pinS1Reg;
  logic [15:0]                    pinS2Reg;
  logic                           csS1Reg;
  logic                           csS2Reg;
  logic                           sclkPrevReg;
  logic [15:0]                    resultReg;
  logic [15:0]                    shiftReg;
  logic [4:0]                     bitCntReg;
  logic [7:0]                     divCntReg;
  logic                           sclkIntReg;
  logic                           busyPrevReg;
  logic                           errPulseReg;
  logic                           errStickyReg;
  logic [ADDR_W-1:0]              awAddrReg;
  logic [31:0]                    wDataReg;
  logic [3:0]                     wStrbReg;
  logic [15:0]                    dataOut_next;
  logic [15:0]                    dataOeN_next;
  logic                           writeFire;
  logic                           isMaster;
  logic                           masterRac;
  logic                           updEdge;
  logic                           busyRise;
  logic [7:0]                     halfPeriod;
  logic [15:0]                    codedResult;

  // Output coding applied to every result leaving the block
  function automatic logic [15:0] applyCoding(input logic [15:0] raw, input logic straight);
    applyCoding = straight ? raw : {~raw[15], raw[14:0]};
  endfunction : applyCoding

  // Half period of the internal serial clock, slowed by the divider pins
  function automatic logic [7:0] halfCount(input logic [7:0] base, input logic [1:0] div);
    halfCount = base << div;
  endfunction : halfCount

  // Mode decode from the configuration word and the conversion start edge
  assign cfg       = adcop_cfg_t'(configReg);
  assign isMaster  = cfg.portType && !cfg.clockSource;
  assign masterRac = isMaster && !cfg.readMode;
  assign busyRise  = convIn.busy && !busyPrevReg;
  // Divider pins only count in master read-after-convert
  assign halfPeriod = halfCount(BASE_HALF, masterRac ?
                      {pinS2Reg[`ADCOP_PIN_DIV1], pinS2Reg[`ADCOP_PIN_DIV0]} : 2'h0);
  // Slave update edge: rising when not inverted, falling when inverted
  // Host clock phases under one sys_clk cycle can be lost in the synchroniser
  assign updEdge = cfg.sclkInvert ?
                   (sclkPrevReg && !pinS2Reg[`ADCOP_PIN_SCLK]) :
                   (!sclkPrevReg && pinS2Reg[`ADCOP_PIN_SCLK]);
  // Both halves of a write are in and no answer is pending yet
  assign writeFire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  // One coded copy of the result feeds the parallel pins and the register readback
  assign codedResult = applyCoding(resultReg, cfg.codingSelect);

  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pinS1Reg    <= 16'h0000;
      pinS2Reg    <= 16'h0000;
      csS1Reg     <= 1'b1;
      csS2Reg     <= 1'b1;
      sclkPrevReg <= 1'b0;
    end else begin
      pinS1Reg    <= dataIn;
      pinS2Reg    <= pinS1Reg;
      csS1Reg     <= csN;
      csS2Reg     <= csS1Reg;
      sclkPrevReg <= pinS2Reg[`ADCOP_PIN_SCLK];
    end
  end

  // Latest conversion result, kept for the parallel bus and the result register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      resultReg   <= 16'h0000;
      busyPrevReg <= 1'b0;
    end else begin
      busyPrevReg <= convIn.busy;
      if (convIn.done) begin
        resultReg <= convIn.data;
      end
    end
  end

  // Serial engine: master shifting on the internal clock, slave on host clock
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stateReg    <= ST_IDLE;
      shiftReg    <= 16'h0000;
      bitCntReg   <= 5'h00;
      divCntReg   <= 8'h00;
      sclkIntReg  <= 1'b0;
      errPulseReg <= 1'b0;
    end else begin
      errPulseReg <= 1'b0;
      case (stateReg)
        ST_IDLE: begin
          bitCntReg  <= 5'h00;
          sclkIntReg <= 1'b0;
          divCntReg  <= 8'h00;
          if (isMaster && cfg.readMode && busyRise) begin
            // Previous result goes out while the new one converts
            shiftReg <= applyCoding(resultReg, cfg.codingSelect);
            stateReg <= ST_MSHIFT;
          end else if (isMaster && !cfg.readMode && convIn.done) begin
            // Fresh result only once the conversion has ended
            shiftReg <= applyCoding(convIn.data, cfg.codingSelect);
            stateReg <= ST_MSHIFT;
          end else if (cfg.portType && cfg.clockSource) begin
            if (convIn.done) begin
              shiftReg <= applyCoding(convIn.data, cfg.codingSelect);
            end
            // Host clock is ignored until chip select is asserted
            if (!csS2Reg) begin
              stateReg <= ST_SREAD;
            end
          end
        end
        ST_MSHIFT: begin
          // Divider pins are read live, so a change mid-frame alters the period
          if (divCntReg + 8'h01 >= halfPeriod) begin
            divCntReg  <= 8'h00;
            sclkIntReg <= !sclkIntReg;
            if (sclkIntReg) begin
              // End of one serial period: next bit, MSB first
              shiftReg  <= {shiftReg[14:0], 1'b0};
              bitCntReg <= bitCntReg + 5'h01;
              if (bitCntReg == `ADCOP_BITS_PER_WORD - 5'h01) begin
                stateReg <= ST_IDLE;
              end
            end
          end else begin
            divCntReg <= divCntReg + 8'h01;
          end
          if (!isMaster) begin
            stateReg <= ST_IDLE;
          end
        end
        ST_SREAD: begin
          if (convIn.done && bitCntReg < `ADCOP_BITS_PER_WORD) begin
            // Unfinished read loses its data to the new result
            errPulseReg <= 1'b1;
            shiftReg    <= applyCoding(convIn.data, cfg.codingSelect);
            bitCntReg   <= 5'h00;
          end else if (updEdge) begin
            // Chain input fills from the bottom, out after 16 periods
            shiftReg <= {shiftReg[14:0], pinS2Reg[`ADCOP_PIN_CHAIN]};
            if (bitCntReg < `ADCOP_BITS_PER_WORD) begin
              bitCntReg <= bitCntReg + 5'h01;
            end
          end
          // A result landing after the word is out is dropped until deselect
          if (csS2Reg || !cfg.portType || !cfg.clockSource) begin
            stateReg <= ST_IDLE;
          end
        end
        default: begin
          stateReg <= ST_IDLE;
        end
      endcase
    end
  end

  // Pin multiplexer between parallel and serial functions
  always_comb begin
    dataOut_next = 16'h0000;
    dataOeN_next = 16'hFFFF;
    if (!cfg.portType) begin
      dataOeN_next = 16'h0000;
      if (cfg.byteOrder) begin
        // Swapped lanes let an 8-bit host take the high byte first
        dataOut_next = {codedResult[7:0], codedResult[15:8]};
      end else begin
        dataOut_next = codedResult;
      end
    end else begin
      // Lines 0..7 all float: two lowest, divider pins and strap inputs
      dataOeN_next[1:0] = 2'h3;
      dataOeN_next[`ADCOP_PIN_DIV1:`ADCOP_PIN_DIV0] = 2'h3;
      dataOeN_next[`ADCOP_PIN_SERIAL_DATA_OUT] = 1'b0;
      dataOut_next[`ADCOP_PIN_SERIAL_DATA_OUT] = shiftReg[15];
      dataOeN_next[`ADCOP_PIN_SCLK]  = !isMaster;
      dataOut_next[`ADCOP_PIN_SCLK]  = sclkIntReg ^ cfg.sclkInvert;
      if (isMaster) begin
        dataOeN_next[`ADCOP_PIN_SYNC] = 1'b0;
        dataOut_next[`ADCOP_PIN_SYNC] = (stateReg == ST_MSHIFT) ^ cfg.syncPolarity;
      end else begin
        dataOeN_next[`ADCOP_PIN_RDERR] = 1'b0;
        dataOut_next[`ADCOP_PIN_RDERR] = errPulseReg;
      end
    end
  end

  // Registered pins so every output leaves a flip-flop
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dataOut <= 16'h0000;
      dataOeN <= 16'hFFFF;
    end else begin
      dataOut <= dataOut_next;
      dataOeN <= dataOeN_next;
    end
  end

  // Write channels: address and data taken in either order
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ADCOP_RESP_OKAY;
      awAddrReg     <= '0;
      wDataReg      <= 32'h00000000;
      wStrbReg      <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddrReg     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wDataReg     <= s_axi_wdata;
        wStrbReg     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (writeFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddrReg == `ADCOP_OFS_CONFIG || awAddrReg == `ADCOP_OFS_STATUS) ?
                        `ADCOP_RESP_OKAY : `ADCOP_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Configuration register; changes mid-read corrupt the frame in flight
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      configReg <= `ADCOP_CONFIG_RESET;
    end else if (writeFire && awAddrReg == `ADCOP_OFS_CONFIG && wStrbReg[0]) begin
      configReg <= wDataReg[`ADCOP_CONFIG_WIDTH-1:0];
    end
  end

  // Sticky read error; a new error in the clearing cycle wins
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      errStickyReg <= 1'b0;
    end else if (errPulseReg) begin
      errStickyReg <= 1'b1;
    end else if (writeFire && awAddrReg == `ADCOP_OFS_STATUS && wStrbReg[0] &&
                 wDataReg[`ADCOP_STAT_READERR]) begin
      errStickyReg <= 1'b0;
    end
  end

  // Read channel: one read at a time, answer the cycle after the address
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `ADCOP_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `ADCOP_RESP_OKAY;
        case (s_axi_araddr)
          `ADCOP_OFS_CONFIG: s_axi_rdata <= {25'h0000000, configReg};
          `ADCOP_OFS_STATUS: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rdata[`ADCOP_STAT_SHIFTING] <= (stateReg != ST_IDLE);
            s_axi_rdata[`ADCOP_STAT_READERR]  <= errStickyReg;
            s_axi_rdata[`ADCOP_STAT_STATE_LO +: 5] <= bitCntReg;
          end
          `ADCOP_OFS_RESULT: s_axi_rdata <= {16'h0000, codedResult};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ADCOP_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule : adcop_port

/* File: core/adcop_regs.svh */
/*
  Constants of the converter output-port block: register offsets, field
  positions, reset values and bus answers.
  Assumes it is included by its bare name wherever the numbers are needed.
*/
`ifndef ADCOP_REGS_SVH
`define ADCOP_REGS_SVH

`define ADCOP_OFS_CONFIG     4'h0
`define ADCOP_OFS_STATUS     4'h4
`define ADCOP_OFS_RESULT     4'h8

`define ADCOP_CONFIG_RESET   7'h02
`define ADCOP_CONFIG_WIDTH   7
`define ADCOP_STAT_SHIFTING  0
`define ADCOP_STAT_READERR   1
`define ADCOP_STAT_STATE_LO  4

`define ADCOP_RESP_OKAY      2'h0
`define ADCOP_RESP_SLVERR    2'h2

`define ADCOP_PIN_DIV0       2
`define ADCOP_PIN_DIV1       3
`define ADCOP_PIN_CHAIN      7
`define ADCOP_PIN_SERIAL_DATA_OUT      8
`define ADCOP_PIN_SCLK       9
`define ADCOP_PIN_SYNC       10
`define ADCOP_PIN_RDERR      11

`define ADCOP_BITS_PER_WORD  5'h10

`endif

/* File: core/adcop_pkg.sv */
/*
  Types of the converter output-port block: strap configuration, the
  conversion-core handshake and the serial state machine.
  Assumes the constants header is compiled alongside.
*/
package adcop_pkg;

  // Configuration word, MSB first so a cast from the register lines up
  typedef struct packed {
    logic readMode;      // read_mode_or_chain_input as read mode select
    logic sclkInvert;    // serial_clock_invert
    logic syncPolarity;  // frame_sync_polarity
    logic clockSource;   // clock_source_select
    logic portType;      // port_type_select
    logic codingSelect;  // coding_select
    logic byteOrder;     // byte_order_select
  } adcop_cfg_t;

  // Handshake from the conversion core, same clock
  typedef struct packed {
    logic        busy;   // Conversion in progress
    logic        done;   // One-cycle pulse, result valid
    logic [15:0] data;   // Raw result
  } adcop_conv_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MSHIFT,
    ST_SREAD
  } adcop_state_t;

endpackage : adcop_pkg

/* File: tb/adcop_port_props.sv */
/*
  Checker for the converter output port: pin enables per mode, the read
  error pulse and the register bus answers.
  Assumes it is bound to adcop_port and sees only its ports.
*/
`timescale 1ns/100ps

module adcop_port_props (
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic [15:0] dataOut,
  input wire logic [15:0] dataOeN,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // Serial mode shows as D0 floating, so every pin rule keys off it
  a_low_pair: assert property (dataOeN[0] |-> dataOeN[1])
    else $error("D1 driven in serial mode");
  a_par_drive: assert property (!dataOeN[0] |-> dataOeN == 16'h0000)
    else $error("parallel bus not fully driven");
  a_div_float: assert property (dataOeN[0] |-> &dataOeN[3:2])
    else $error("divider pins driven in serial mode");
  a_ser_float: assert property (dataOeN[0] |-> &dataOeN[7:4] && &dataOeN[15:12])
    else $error("strap pins driven in serial mode");
  a_master_pins: assert property (dataOeN[0] && !dataOeN[9] |->
    !dataOeN[8] && !dataOeN[10] && dataOeN[11]) else $error("master pin set wrong");
  // The all-float reset value still stands at the first edge after release
  a_slave_pins: assert property (!$past(srst) && dataOeN[0] && dataOeN[9] |->
    !dataOeN[8] && !dataOeN[11]) else $error("slave pin set wrong");
  // A flag wider than one cycle would be read as two errors
  a_err_pulse: assert property (dataOeN[0] && !dataOeN[11] && dataOut[11]
    |=> !dataOut[11]) else $error("read error pulse too long");
  a_aw_block: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write accepted");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer not held");

  c_parallel: cover property (!dataOeN[0]);
  c_master: cover property (dataOeN[0] && !dataOeN[9]);
  c_slave: cover property (dataOeN[0] && dataOeN[9]);
  c_error: cover property (dataOeN[0] && !dataOeN[11] && dataOut[11]);
endmodule : adcop_port_props

bind adcop_port adcop_port_props u_props (
  .sys_clk(sys_clk), .srst(srst), .dataOut(dataOut), .dataOeN(dataOeN),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata)
);

/* File: tb/adcop_host.sv */
/*
  Host model on the shared data pins: serial clock, chip select, chain
  input and divider straps, and the resolved pin levels.
  Assumes active-low device enables and that the bench calls host_read.
*/
`timescale 1ns/100ps

module adcop_host (
  input  wire logic        sys_clk,
  input  wire logic [15:0] dataOut,
  input  wire logic [15:0] dataOeN,
  output logic [15:0]      dataIn,
  output logic             csN
);
  localparam logic [15:0] HOST_EN = 16'h028C; // Divider, chain, clock
  logic [15:0] hostVal;
  logic        wobble;

  // Divider 01, chain input high, clock idles low outside frames
  initial begin
    hostVal = 16'h0084;
    csN     = 1'h1;
    wobble  = 1'h0;
  end

  // Floating lines keep changing so a stale level never passes for data
  always @(posedge sys_clk) wobble <= ~wobble;

  // Device drive wins; the host drives its lines only where the device floats
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      dataIn[i] = !dataOeN[i] ? dataOut[i] : (HOST_EN[i] ? hostVal[i] : wobble ^ i[0]);
    end
  end

  // Slow clock, 8 sys_clk per phase; each bit is taken just before the rising
  // edge, at least a full phase after either update edge, so both edge senses are served
  task automatic host_read(input int n, output logic [31:0] bits);
    bits = '0;
    csN <= 1'h0;
    repeat (8) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      bits = {bits[30:0], dataOut[8]};
      hostVal[9] <= 1'h1;
      repeat (8) @(posedge sys_clk);
      hostVal[9] <= 1'h0;
      repeat (8) @(posedge sys_clk);
    end
    csN <= 1'h1;
  endtask : host_read
endmodule : adcop_host

/* File: tb/adcop_port_tb_top.sv */
/*
  Self-checking bench for the converter output port: registers, parallel
  lanes and coding, serial master and slave, read error flag.
  Assumes the host model resolves the shared pins.
*/
`timescale 1ns/100ps
`include "adcop_regs.svh"

`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin miscompares++; \
  $display("[FAIL] %s exp %h got %h", nm, exp, got); end end

module adcop_port_tb_top;
  import adcop_pkg::*;
  localparam logic [7:0] HALF = 8'h02;
  logic        sys_clk = 1'h0, srst = 1'h1, csN;
  adcop_conv_t conv = '0;
  logic [15:0] dataIn, dataOut, dataOeN;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          miscompares = 0, checked = 0, cyc = 0;

  adcop_port #(.ADDR_W(4), .BASE_HALF(HALF)) uut (
    .sys_clk(sys_clk), .srst(srst), .convIn(conv), .dataIn(dataIn), .dataOut(dataOut),
    .dataOeN(dataOeN), .csN(csN), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  adcop_host host (.sys_clk(sys_clk), .dataOut(dataOut), .dataOeN(dataOeN),
    .dataIn(dataIn), .csN(csN));

  always #2 sys_clk = ~sys_clk;

  // Whole run needs about 1200 cycles; a hang ends at the ceiling
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Expected parallel pins from coding and byte order bits
  function automatic logic [15:0] lanes(input logic [1:0] c, input logic [15:0] d);
    logic [15:0] v;
    v = c[1] ? d : {~d[15], d[14:0]};
    return c[0] ? {v[7:0], v[15:8]} : v;
  endfunction : lanes

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge sys_clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge sys_clk);
  endtask : axi_rd

  task automatic conv_done(input logic [15:0] d);
    conv.data <= d;
    conv.done <= 1'h1;
    @(posedge sys_clk);
    conv.done <= 1'h0;
  endtask : conv_done

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(`ADCOP_OFS_CONFIG, d, r);
    `CHK("config reset", 32'(`ADCOP_CONFIG_RESET), d)
    axi_rd(4'hC, d, r);
    `CHK("unmapped resp", `ADCOP_RESP_SLVERR, r)
    `CHK("unmapped data", 32'h0, d)
    axi_wr(`ADCOP_OFS_RESULT, 32'hFFFF, r);
    `CHK("result write", `ADCOP_RESP_SLVERR, r)
    $display("test regs done");
  endtask : t_regs

  // All four coding and byte order settings on one result
  task automatic t_parallel();
    logic [1:0] r;
    for (int c = 0; c < 4; c++) begin
      axi_wr(`ADCOP_OFS_CONFIG, 32'(c), r);
      conv_done(16'h1234);
      repeat (3) @(posedge sys_clk);
      `CHK("parallel pins", lanes(2'(c), 16'h1234), dataOut)
      `CHK("parallel drive", 16'h0000, dataOeN)
    end
    $display("test parallel done");
  endtask : t_parallel

  // Sample on the edge after the shift edge; the pin idles at the invert level
  task automatic capture(input logic inv, pol, input int per, input logic [15:0] exp);
    logic [15:0] bits;
    logic        syncOk;
    int          t0;
    bits = '0;
    syncOk = 1'h1;
    t0 = 0;
    for (int i = 0; i < 16; i++) begin
      while (dataOut[9] !== inv) @(posedge sys_clk);
      while (dataOut[9] !== ~inv) @(posedge sys_clk);
      bits = {bits[14:0], dataOut[8]};
      syncOk &= (dataOut[10] === ~pol);
      if (i == 1) t0 = cyc;
      if (i == 2) `CHK("clock period", per, cyc - t0)
    end
    `CHK("master bits", exp, bits)
    `CHK("sync held", 1'h1, syncOk)
  endtask : capture

  task automatic t_master();
    logic [1:0] r;
    axi_wr(`ADCOP_OFS_CONFIG, 32'h06, r);
    conv_done(16'hA5C3);
    capture(1'h0, 1'h0, 2 * (HALF << 1), 16'hA5C3);
    `CHK("serial low float", 2'h3, dataOeN[1:0])
    repeat (20) @(posedge sys_clk);
    axi_wr(`ADCOP_OFS_CONFIG, 32'h76, r);
    conv.busy <= 1'h1;
    capture(1'h1, 1'h1, 2 * HALF, 16'hA5C3);
    conv.busy <= 1'h0;
    repeat (20) @(posedge sys_clk);
    $display("test master done");
  endtask : t_master

  // Host clock while deselected must leave the word alone; both edge senses
  task automatic t_slave();
    logic [1:0]  r;
    logic [31:0] b;
    for (int k = 0; k < 2; k++) begin
      axi_wr(`ADCOP_OFS_CONFIG, k ? 32'h2E : 32'h0E, r);
      conv_done(k ? 16'hC35A : 16'h5A3C);
      repeat (3) begin
        host.hostVal[9] <= 1'h1;
        repeat (8) @(posedge sys_clk);
        host.hostVal[9] <= 1'h0;
        repeat (8) @(posedge sys_clk);
      end
      host.host_read(20, b);
      `CHK("slave bits", k ? 20'hC35AF : 20'h5A3CF, b[19:0])
    end
    $display("test slave done");
  endtask : t_slave

  // A conversion lands two bits into a host read
  task automatic t_error();
    logic [1:0]  r;
    logic [31:0] b, d;
    logic        seen;
    seen = 1'h0;
    @(posedge sys_clk);
    fork
      host.host_read(6, b);
      begin
        repeat (40) @(posedge sys_clk);
        conv_done(16'h0F0F);
        repeat (8) begin
          @(posedge sys_clk);
          if (dataOut[11] === 1'h1 && dataOeN[11] === 1'h0) seen = 1'h1;
        end
      end
    join
    `CHK("error pulse", 1'h1, seen)
    axi_rd(`ADCOP_OFS_STATUS, d, r);
    `CHK("error sticky", 1'h1, d[`ADCOP_STAT_READERR])
    axi_wr(`ADCOP_OFS_STATUS, 32'h2, r);
    axi_rd(`ADCOP_OFS_STATUS, d, r);
    `CHK("error cleared", 1'h0, d[`ADCOP_STAT_READERR])
    $display("test error done");
  endtask : t_error

  initial begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'h0;
    @(posedge sys_clk);
    t_regs();
    t_parallel();
    t_master();
    t_slave();
    t_error();
    print_verdict();
  end
endmodule : adcop_port_tb_top
